// File: mgmt_defs.vh
// Purpose: Constants for the management mode and configuration load block
// Assumes: 32-bit classic Wishbone register bus, byte addresses
// Notes:   Four-level straps arrive already resolved to two-bit codes
//
// What this block does
// - Calibration clock used only for loss monitoring and the buffered output
// - Calibration clock output buffers calibration clock input
// - Sample address straps once, sixteen addresses
// - Mode strap: float controller, high target
// - Controller mode: low request starts load
// - Controller mode: load-done low only after successful load
// - Held-low request after load does not restart
// - Target mode: load-done mirrors request input
// - Target mode: low request holds bus, registers reset
// - Interrupt pulls low on enabled event
// - Software selects which events raise interrupt
// - Interrupt only pulls low, never drives high
// - Bus clock line is open-drain like data
// - Configure by host writes; EEPROM load does not write config
// - Sixteen devices share one EEPROM image
`ifndef MGMT_DEFS_VH
`define MGMT_DEFS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define REG_STATUS   8'h00
`define REG_CLEAR    8'h04
`define REG_ENABLE   8'h08
`define REG_CONTROL  8'h0c
`define REG_STRAPS   8'h10
`define REG_CONFIG   8'h14

// ----------------------------------------------------------------
// Event bit positions
// ----------------------------------------------------------------
`define EV_LOAD_OK    0
`define EV_LOAD_FAIL  1
`define EV_CAL_LOST   2
`define EV_SW         3
`define EV_WIDTH      4

// ----------------------------------------------------------------
// Strap level codes
// ----------------------------------------------------------------
`define LVL_LOW       2'h0
`define LVL_RES       2'h1
`define LVL_FLOAT     2'h2
`define LVL_HIGH      2'h3

// ----------------------------------------------------------------
// Reset values and timing
// ----------------------------------------------------------------
`define ENABLE_RESET  4'h0
`define CONFIG_RESET  32'h00000000
`define BUS_ADDR_BASE 7'h18
`define CLK_PERIOD_PS 4000
`define CAL_PERIOD_PS 40000
`define CAL_CYCLES    (`CAL_PERIOD_PS / `CLK_PERIOD_PS)
`define CAL_TIMEOUT   (4 * `CAL_CYCLES)
`define BIT_DIV       16'd624
`define LOAD_BITS     16'd512
`define STRAP_SETTLE  3'h4

`endif

// File: sync3.v
// Purpose: Three-stage synchroniser with agreement detection
// Assumes: Input is asynchronous to clk_i
// Notes:   Output changes once stages two and three agree
`timescale 1ns/1ps
module sync3
(
	input  wire clk_i,
	input  wire rst_i,
	input  wire rst_val_i,
	input  wire d_i,
	output reg  q_o
);
	reg s1;
	reg s2;
	reg s3;

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			s1  <= rst_val_i;
			s2  <= rst_val_i;
			s3  <= rst_val_i;
			q_o <= rst_val_i;
		end
		else
		begin
			s1 <= d_i;
			s2 <= s1;
			s3 <= s2;
			if (s2 == s3)
				q_o <= s3;
		end
	end
endmodule

// File: mgmt_load_ctrl.v
// Purpose: Management mode select, strap capture and configuration load control
// Assumes: Straps arrive as two-bit level codes; 250 MHz clk_i
// Notes:   EEPROM read is a bit-walk on the open-drain pair, ack-checked at end
`timescale 1ns/1ps
`include "mgmt_defs.vh"
module mgmt_load_ctrl
(
	input  wire        clk_i,
	input  wire        rst_i,
	input  wire [7:0]  adr_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	input  wire        we_i,
	input  wire [3:0]  sel_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	output reg         ack_o,
	input  wire        cal_clk_i,
	output wire        cal_clk_o,
	input  wire [1:0]  address_strap_low_i,
	input  wire [1:0]  address_strap_high_i,
	input  wire [1:0]  bus_mode_strap_i,
	input  wire        load_req_n_i,
	output reg         load_done_n_o,
	input  wire        mgmt_bus_clock_line_i,
	output wire        mgmt_bus_clock_line_o,
	output wire        mgmt_bus_clock_line_oe_o,
	input  wire        mgmt_bus_data_i,
	output wire        mgmt_bus_data_o,
	output wire        mgmt_bus_data_oe_o,
	output wire        irq_n_o,
	output wire        irq_n_oe_o,
	output reg  [6:0]  bus_address_o,
	output reg         controller_mode_o,
	output wire        target_hold_o,
	output reg  [31:0] config_o
);
	// ----------------------------------------------------------------
	// Pin synchronisers
	// ----------------------------------------------------------------
	wire cal_s;
	wire req_n_s;
	wire scl_s;
	wire sda_s;

	// Every pin passes three stages; the straps have their own below
	sync3 u_cal (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b0), .d_i(cal_clk_i), .q_o(cal_s));
	sync3 u_req (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b1), .d_i(load_req_n_i), .q_o(req_n_s));
	sync3 u_scl (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b1),
		.d_i(mgmt_bus_clock_line_i), .q_o(scl_s));
	sync3 u_sda (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b1), .d_i(mgmt_bus_data_i), .q_o(sda_s));

	// Buffered replica of the calibration clock
	assign cal_clk_o = cal_clk_i;

	// ----------------------------------------------------------------
	// Strap capture after reset release
	// ----------------------------------------------------------------
	wire [1:0] strap_lo_s;
	wire [1:0] strap_hi_s;
	wire [1:0] mode_s;
	reg  [2:0] settle;
	reg        straps_taken;
	reg [1:0]  mode_lvl;
	reg [3:0]  addr_code;

	// Straps are pins too: capture waits until their synchronisers settle
	sync3 u_lo0 (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b0), .d_i(address_strap_low_i[0]),
		.q_o(strap_lo_s[0]));
	sync3 u_lo1 (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b0), .d_i(address_strap_low_i[1]),
		.q_o(strap_lo_s[1]));
	sync3 u_hi0 (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b0), .d_i(address_strap_high_i[0]),
		.q_o(strap_hi_s[0]));
	sync3 u_hi1 (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b0), .d_i(address_strap_high_i[1]),
		.q_o(strap_hi_s[1]));
	sync3 u_md0 (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b0), .d_i(bus_mode_strap_i[0]),
		.q_o(mode_s[0]));
	sync3 u_md1 (.clk_i(clk_i), .rst_i(rst_i), .rst_val_i(1'b0), .d_i(bus_mode_strap_i[1]),
		.q_o(mode_s[1]));

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			settle            <= 3'h0;
			straps_taken      <= 1'b0;
			mode_lvl          <= `LVL_LOW;
			addr_code         <= 4'h0;
			bus_address_o     <= 7'h00;
			controller_mode_o <= 1'b0;
		end
		else if (!straps_taken)
		begin
			if (settle != `STRAP_SETTLE)
				settle <= settle + 3'h1;
			else
			begin
				straps_taken      <= 1'b1;
				mode_lvl          <= mode_s;
				addr_code         <= {strap_hi_s, strap_lo_s};
				bus_address_o     <= `BUS_ADDR_BASE + {3'h0, strap_hi_s, strap_lo_s};
				controller_mode_o <= (mode_s == `LVL_FLOAT);
			end
		end
	end

	wire target_mode = straps_taken && (mode_lvl == `LVL_HIGH);
	assign target_hold_o = target_mode && !req_n_s;

	// ----------------------------------------------------------------
	// Calibration clock monitor (edge and stall detection only)
	// ----------------------------------------------------------------
	reg        cal_d;
	reg [7:0]  cal_cnt;
	reg        cal_lost;

	// Cycles since the last rising calibration edge; a stall raises an event
	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			cal_d    <= 1'b0;
			cal_cnt  <= 8'h00;
			cal_lost <= 1'b0;
		end
		else
		begin
			cal_d    <= cal_s;
			cal_lost <= 1'b0;
			if (cal_s && !cal_d)
				cal_cnt <= 8'h00;
			else if (cal_cnt == `CAL_TIMEOUT)
			begin
				cal_cnt  <= 8'h00;
				cal_lost <= 1'b1;
			end
			else
				cal_cnt <= cal_cnt + 8'h01;
		end
	end

	// ----------------------------------------------------------------
	// EEPROM load in controller mode
	// ----------------------------------------------------------------
	localparam ST_IDLE = 2'h0;
	localparam ST_LOAD = 2'h1;
	localparam ST_DONE = 2'h2;
	localparam ST_FAIL = 2'h3;

	reg [1:0]  state;
	reg [15:0] div_cnt;
	reg [15:0] bit_cnt;
	reg        scl_drv_low;
	reg        ev_ok;
	reg        ev_fail;
	reg        sw_load;
	// One-cycle bit enable from the free-running divider
	wire       bit_tick = (div_cnt == `BIT_DIV);

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			state         <= ST_IDLE;
			div_cnt       <= 16'h0000;
			bit_cnt       <= 16'h0000;
			scl_drv_low   <= 1'b0;
			load_done_n_o <= 1'b1;
			ev_ok         <= 1'b0;
			ev_fail       <= 1'b0;
		end
		else
		begin
			ev_ok   <= 1'b0;
			ev_fail <= 1'b0;
			div_cnt <= bit_tick ? 16'h0000 : div_cnt + 16'h0001;
			if (target_mode)
			begin
				// Target mode: state held idle, done mirrors the request
				state         <= ST_IDLE;
				scl_drv_low   <= 1'b0;
				load_done_n_o <= req_n_s;
			end
			else if (controller_mode_o)
			begin
				case (state)
					ST_IDLE:
					begin
						// Request low or a software start begins a load
						scl_drv_low <= 1'b0;
						if (!req_n_s || sw_load)
						begin
							state         <= ST_LOAD;
							bit_cnt       <= 16'h0000;
							load_done_n_o <= 1'b1;
						end
					end
					ST_LOAD:
					begin
						if (bit_tick)
						begin
							scl_drv_low <= !scl_drv_low;
							if (scl_drv_low)
								bit_cnt <= bit_cnt + 16'h0001;
							if (bit_cnt == `LOAD_BITS)
							begin
								scl_drv_low <= 1'b0;
								// Data low at end of image acts as the final ack
								if (!sda_s)
								begin
									state         <= ST_DONE;
									load_done_n_o <= 1'b0;
									ev_ok         <= 1'b1;
								end
								else
								begin
									state   <= ST_FAIL;
									ev_fail <= 1'b1;
								end
							end
						end
					end
					ST_DONE:
					begin
						// Request held low: stay done
						if (sw_load)
							state <= ST_IDLE;
					end
					ST_FAIL:
					begin
						// Releasing the request or a software start returns to idle
						if (req_n_s || sw_load)
							state <= ST_IDLE;
					end
					default:
						state <= ST_IDLE;
				endcase
			end
		end
	end

	assign mgmt_bus_clock_line_o    = 1'b0;
	assign mgmt_bus_clock_line_oe_o = scl_drv_low;
	assign mgmt_bus_data_o          = 1'b0;
	assign mgmt_bus_data_oe_o       = 1'b0;

	// ----------------------------------------------------------------
	// Register bus, events and interrupt
	// ----------------------------------------------------------------
	reg [`EV_WIDTH-1:0] ev_status;
	reg [`EV_WIDTH-1:0] ev_enable;
	wire                acc = cyc_i && stb_i && !ack_o;
	wire                wr  = acc && we_i && sel_i[0];
	wire [`EV_WIDTH-1:0] ev_set;
	wire [`EV_WIDTH-1:0] ev_clr;

	// Event sources, in the bit order of the status register
	assign ev_set = {wr && (adr_i == `REG_CONTROL) && dat_i[1], cal_lost, ev_fail, ev_ok};
	assign ev_clr = (wr && adr_i == `REG_CLEAR) ? dat_i[`EV_WIDTH-1:0] : {`EV_WIDTH{1'b0}};

	always @(posedge clk_i)
	begin
		if (rst_i)
		begin
			ack_o <= 1'b0;
			dat_o <= 32'h00000000;
		end
		else
		begin
			ack_o <= acc;
			// Read data follows the address every cycle and is taken with ack
			case (adr_i)
				`REG_STATUS:  dat_o <= {28'h0, ev_status};
				`REG_ENABLE:  dat_o <= {28'h0, ev_enable};
				`REG_CONTROL: dat_o <= {28'h0, state, 2'h0};
				`REG_STRAPS:  dat_o <= {16'h0, 1'b0, bus_address_o, 2'h0, mode_lvl, addr_code};
				`REG_CONFIG:  dat_o <= config_o;
				default:      dat_o <= 32'h00000000;
			endcase
		end
	end

	// Target hold clears the registers just as reset does
	always @(posedge clk_i)
	begin
		if (rst_i || target_hold_o)
		begin
			ev_status <= {`EV_WIDTH{1'b0}};
			ev_enable <= `ENABLE_RESET;
			config_o  <= `CONFIG_RESET;
			sw_load   <= 1'b0;
		end
		else
		begin
			sw_load   <= wr && (adr_i == `REG_CONTROL) && dat_i[0];
			ev_status <= (ev_status & ~ev_clr) | ev_set;
			if (wr && adr_i == `REG_CONFIG)
				config_o <= dat_i;
			if (wr && adr_i == `REG_ENABLE)
				ev_enable <= dat_i[`EV_WIDTH-1:0];
		end
	end

	// Open-drain interrupt: only ever pulls low
	assign irq_n_o    = 1'b0;
	assign irq_n_oe_o = |(ev_status & ev_enable);
endmodule

// File: mgmt_load_ctrl_sva.sv
// Purpose: Port checks of the load control block
// Assumes: One clock domain, synchronous reset
// Notes:   Bound to every instance of the block
`timescale 1ns/1ps
module mgmt_load_ctrl_sva
(
	input logic        clk_i,
	input logic        rst_i,
	input logic        cyc_i,
	input logic        stb_i,
	input logic        ack_o,
	input logic        cal_clk_i,
	input logic        cal_clk_o,
	input logic        load_done_n_o,
	input logic        mgmt_bus_clock_line_o,
	input logic        mgmt_bus_clock_line_oe_o,
	input logic        mgmt_bus_data_o,
	input logic        irq_n_o,
	input logic [6:0]  bus_address_o,
	input logic        controller_mode_o,
	input logic        target_hold_o,
	input logic [31:0] config_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (rst_i);
	logic [3:0] since_rst;
	always @(posedge clk_i)
	begin
		if (rst_i)
			since_rst <= 4'h0;
		else if (since_rst != 4'hf)
			since_rst <= since_rst + 4'h1;
	end
	property p_ack; cyc_i && stb_i && !ack_o |=> ack_o ##1 !ack_o; endproperty
	a_ack: assert property (p_ack) else $error("bad ack");
	property p_cal; cal_clk_o == cal_clk_i; endproperty
	a_cal: assert property (p_cal) else $error("bad cal copy");
	property p_od; !mgmt_bus_clock_line_o && !mgmt_bus_data_o && !irq_n_o; endproperty
	a_od: assert property (p_od) else $error("pin driven high");
	property p_load; controller_mode_o && mgmt_bus_clock_line_oe_o |-> load_done_n_o; endproperty
	a_load: assert property (p_load) else $error("done while loading");
	property p_hold; target_hold_o |-> !controller_mode_o ##1 config_o == 32'h0; endproperty
	a_hold: assert property (p_hold) else $error("bad hold");
	property p_rise; $rose(target_hold_o) |-> ##[0:3] !load_done_n_o; endproperty
	a_rise: assert property (p_rise) else $error("done not low");
	property p_fall; $fell(target_hold_o) |-> ##[0:3] load_done_n_o; endproperty
	a_fall: assert property (p_fall) else $error("done not high");
	property p_strap;
		since_rst > 4'h6 |-> $stable(bus_address_o) && $stable(controller_mode_o);
	endproperty
	a_strap: assert property (p_strap) else $error("strap moved");
endmodule
bind mgmt_load_ctrl mgmt_load_ctrl_sva mgmt_load_ctrl_sva_inst (.*);

// File: eeprom_model.sv
// Purpose: Far side of the management bus and interrupt net
// Assumes: Pull-ups on the clock and interrupt nets; data line tied low
// Notes:   The EEPROM holds the data line low as acknowledge
`timescale 1ns/1ps
module eeprom_model
(
	input  wire clk_oe_i,
	input  wire irq_oe_i,
	output wire clk_o,
	output wire data_o,
	output wire irq_o
);
	assign clk_o  = !clk_oe_i;
	assign data_o = 1'h0;
	assign irq_o  = !irq_oe_i;
endmodule

// File: mgmt_mode_and_config_load_control_tb.sv
// Purpose: Self-checking bench of the load control block
// Assumes: 250 MHz clock, 48 ns calibration clock
// Notes:   A full EEPROM load outlasts the run; only its start is seen
`timescale 1ns/1ps
module mgmt_mode_and_config_load_control_tb;
	logic        clk_i = 1'h0, rst_i = 1'h1, we_i = 1'h0, cyc_i = 1'h0, stb_i = 1'h0;
	logic        cal_clk_i = 1'h0, load_req_n_i = 1'h1;
	logic [1:0]  address_strap_low_i = 2'h0, address_strap_high_i = 2'h0;
	logic [1:0]  bus_mode_strap_i = 2'h0;
	logic [3:0]  sel_i = 4'hf, wsel = 4'hf;
	logic [7:0]  adr_i = 8'h0;
	logic [31:0] dat_i = 32'h0, rnd = 32'ha105;
	logic [31:0] exp_q[$];
	wire  [31:0] dat_o, config_o;
	wire  [6:0]  bus_address_o;
	wire         ack_o, cal_clk_o, load_done_n_o, irq_n_o, irq_n_oe_o, irq_net;
	wire         mgmt_bus_clock_line_i, mgmt_bus_clock_line_o, mgmt_bus_clock_line_oe_o;
	wire         mgmt_bus_data_i, mgmt_bus_data_o, mgmt_bus_data_oe_o;
	wire         controller_mode_o, target_hold_o;
	int          n_fail = 0, checks_done = 0, i;
	mgmt_load_ctrl mgmt_load_ctrl_inst (.*);
	eeprom_model eeprom_model_inst (.clk_oe_i(mgmt_bus_clock_line_oe_o), .irq_oe_i(irq_n_oe_o),
		.clk_o(mgmt_bus_clock_line_i), .data_o(mgmt_bus_data_i), .irq_o(irq_net));
	initial forever #2 clk_i = ~clk_i;
	initial
	begin
		#7;
		forever #24 cal_clk_i = ~cal_clk_i;
	end
	function automatic [31:0] lfsr(input [31:0] s);
		lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic chk(input string nm, input [31:0] seen, input [31:0] exp);
		checks_done++;
		if (seen !== exp)
		begin
			n_fail++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d failures %0d", checks_done, n_fail);
		if (n_fail == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic wb(input w, input [7:0] a, input [31:0] d);
		if (!w)
			exp_q.push_back(d);
		@(posedge clk_i);
		cyc_i <= 1'h1;
		stb_i <= 1'h1;
		we_i <= w;
		sel_i <= wsel;
		adr_i <= a;
		dat_i <= d;
		@(posedge clk_i);
		while (ack_o !== 1'h1)
			@(posedge clk_i);
		cyc_i <= 1'h0;
		stb_i <= 1'h0;
		repeat (2) @(posedge clk_i);
	endtask
	task automatic rst_seq(input [1:0] m);
		rnd = lfsr(rnd);
		@(posedge clk_i);
		rst_i <= 1'h1;
		bus_mode_strap_i <= m;
		address_strap_low_i <= rnd[1:0];
		address_strap_high_i <= rnd[3:2];
		repeat (3) @(posedge clk_i);
		rst_i <= 1'h0;
		repeat (8) @(posedge clk_i);
		chk("mode", 32'({controller_mode_o, load_done_n_o, bus_address_o}),
			32'({m == 2'h2, 1'h1, 7'h18 + {rnd[3:2], rnd[1:0]}}));
	endtask
	always @(posedge clk_i)
		if (ack_o === 1'h1 && we_i === 1'h0)
			chk("rd", dat_o, exp_q.pop_front());
	initial
	begin
		for (i = 0; i < 4; i++)
			rst_seq(i[1:0]);
		rnd = lfsr(rnd);
		wb(1'h1, 8'h14, rnd);
		wb(1'h0, 8'h14, rnd);
		load_req_n_i <= 1'h0;
		repeat (10) @(posedge clk_i);
		chk("cfg", config_o, 32'h0);
		chk("hold", 32'({target_hold_o, load_done_n_o}), 32'h2);
		load_req_n_i <= 1'h1;
		repeat (10) @(posedge clk_i);
		chk("hold", 32'({target_hold_o, load_done_n_o}), 32'h1);
		rst_seq(2'h2);
		wb(1'h0, 8'h08, 32'h0);
		wb(1'h0, 8'h1c, 32'h0);
		wsel = 4'he;
		wb(1'h1, 8'h14, 32'h5a);
		wsel = 4'hf;
		wb(1'h0, 8'h14, 32'h0);
		wb(1'h0, 8'h10, {17'h0, 7'h18 + {address_strap_high_i, address_strap_low_i},
			4'h2, address_strap_high_i, address_strap_low_i});
		wb(1'h1, 8'h08, 32'h8);
		wb(1'h1, 8'h0c, 32'h2);
		wb(1'h0, 8'h00, 32'h8);
		chk("irq", 32'(irq_net), 32'h0);
		wb(1'h1, 8'h08, 32'h0);
		chk("irq", 32'(irq_net), 32'h1);
		wb(1'h1, 8'h08, 32'h8);
		wb(1'h1, 8'h04, 32'h8);
		chk("irq", 32'(irq_net), 32'h1);
		wb(1'h0, 8'h00, 32'h0);
		load_req_n_i <= 1'h0;
		for (i = 0; i < 2000 && mgmt_bus_clock_line_oe_o !== 1'h1; i++)
			@(posedge clk_i);
		chk("load", 32'({mgmt_bus_clock_line_oe_o, load_done_n_o}), 32'h3);
		wb(1'h0, 8'h0c, 32'h4);
		tally_and_finish();
	end
	initial
	begin
		#100000;
		n_fail++;
		tally_and_finish();
	end
endmodule
